// file: src/vhc_ctrl.sv
// Hypervisor control register with traps and maintenance signalling
// What this block does
// - Control bit 13 set routes local system errors to hypervisor level.
// - Bit 13 reads zero and ignores writes without error support.
// - Bit 12 set traps guest kernel Group 1 register accesses.
// - Bit 11 set traps guest kernel Group 0 register accesses.
// - Bit 10 set traps guest kernel accesses to common registers.
// - Bit 8 set stops virtual SGI deactivations bumping the counter.
// - Bit 7 set: maintenance interrupt while group 1 signalling is off.
// - Bit 6 set: maintenance interrupt while group 1 signalling is on.
// - Bit 5 set: maintenance interrupt while group 0 signalling is off.
// - Bit 4 set: maintenance interrupt while group 0 signalling is on.
// - Bit 3 set: maintenance interrupt while no entry is pending.
// - Bit 2 set: maintenance interrupt while the counter is nonzero.
// - Bit 1 set: maintenance interrupt while at most one entry valid.
// - Enable clear blocks maintenance and virtual interrupt signalling.
// - Enable clear makes acknowledge reads return the spurious id.
// - Warm reset clears every control field to zero.
// - Hyp or monitor access needs its interface enable; user undefined.
// - Guest kernel access traps with code 3 if hyp enabled and group 12 trap set.
// - Unmatched valid non-LPI deactivations increment the 5-bit counter.
`timescale 1ns/1ns

module vhc_ctrl #(
    parameter int NUM_LR    = 16,
    parameter bit VSGI_FEAT = 1'b1
) (
    input  wire logic                core_clk,
    input  wire logic                nrst,
    // Register access from the core
    input  vhc_pkg::vhc_req_type     sreg_req,
    input  wire logic                hyp_iface_on,
    input  wire logic                mon_iface_on,
    input  wire logic                hyp_enabled,
    input  wire logic                coproc_group12_trap,
    output vhc_pkg::vhc_rsp_type     sreg_rsp,
    // Block state fed from the rest of the interface
    input  vhc_pkg::vhc_lr_type      list_register_entry [NUM_LR],
    input  wire logic                vgroup0_signal_on,
    input  wire logic                vgroup1_signal_on,
    input  wire logic                serror_gen_supported,
    input  wire logic                unmatched_deact,
    input  wire logic                unmatched_is_vsgi,
    // Guest accesses to be classified
    input  wire logic                guest_acc_valid,
    input  wire logic                guest_acc_grp0,
    input  wire logic                guest_acc_grp1,
    input  wire logic                guest_acc_common,
    output logic                     guest_acc_trap,
    // Local system errors
    input  wire logic                local_system_error,
    output logic                     serror_to_hyp,
    output logic                     serror_to_guest,
    // Virtual interrupt path
    input  wire logic                virq_in,
    output logic                     virq_out,
    input  wire logic                iack_rd,
    input  wire logic [23:0]         iack_id_in,
    output logic [23:0]              iack_id_out,
    output logic                     iack_valid,
    // Maintenance interrupt
    output logic                     maint_irq
);
    import vhc_pkg::*;

    // ========================================================
    // Storage
    logic [31:0]      ctrl_reg;
    logic [31:0]      ctrl_next;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    vhc_rsp_type      rsp_reg;
    vhc_rsp_type      rsp_next;
    logic             maint_reg;
    logic             maint_next;
    logic             gtrap_reg;
    logic             serr_hyp_reg;
    logic             serr_guest_reg;
    logic             virq_reg;
    logic [23:0]      iack_reg;
    logic             iack_vld_reg;

    // ========================================================
    // Entry scan helpers
    function automatic logic any_pending(
        input vhc_lr_type lr [NUM_LR]
    );
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_LR; i++) begin
            if (lr[i].state == LR_PENDING) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // Empty means inactive and no unhandled EOI maintenance left
    function automatic logic few_valid(
        input vhc_lr_type lr [NUM_LR]
    );
        int n;
        n = 0;
        for (int i = 0; i < NUM_LR; i++) begin
            if (lr[i].state != LR_INVALID || (!lr[i].hw && lr[i].eoi))
            begin
                n++;
            end
        end
        return (n <= 1);
    endfunction

    // ========================================================
    // Access decode
    logic enc_hit;
    logic lvl_ok;
    logic do_acc;
    logic do_wr;
    logic [31:0] wr_mask;
    logic [31:0] rd_val;

    assign enc_hit = sreg_req.coproc == ENC_COPROC
                  && sreg_req.opc1 == ENC_OPC1
                  && sreg_req.crn  == ENC_CRN
                  && sreg_req.crm  == ENC_CRM
                  && sreg_req.opc2 == ENC_OPC2;

    // Interface enable per privilege level
    assign lvl_ok = (sreg_req.level == LVL_HYP && hyp_iface_on)
                 || (sreg_req.level == LVL_MON && mon_iface_on);

    assign do_acc = sreg_req.valid && enc_hit && lvl_ok;
    assign do_wr  = do_acc && sreg_req.write;

    // Reserved and absent feature bits never stored
    always_comb begin
        wr_mask = CTRL_MASK;
        if (!serror_gen_supported) begin
            wr_mask = wr_mask & ~SERR_MASK;
        end
        if (!VSGI_FEAT) begin
            wr_mask = wr_mask & ~VSGI_MASK;
        end
    end

    // Bit 13 also masked on read if support drops later
    always_comb begin
        rd_val = (ctrl_reg & wr_mask);
        rd_val[CNT_LSB +: CNT_W] = count_reg;
    end

    // ========================================================
    // Response path
    always_comb begin
        rsp_next = '0;
        if (sreg_req.valid) begin
            rsp_next.valid = 1'b1;
            if (!enc_hit) begin
                rsp_next.undef = 1'b1;
            end else if (sreg_req.level == LVL_USER) begin
                rsp_next.undef = 1'b1;
            end else if (sreg_req.level == LVL_KERNEL) begin
                if (hyp_enabled && coproc_group12_trap) begin
                    rsp_next.trap = 1'b1;
                    rsp_next.code = TRAP_CODE;
                end else begin
                    rsp_next.undef = 1'b1;
                end
            end else if (!lvl_ok) begin
                rsp_next.undef = 1'b1;
            end else if (!sreg_req.write) begin
                rsp_next.rdata = rd_val;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    assign sreg_rsp = rsp_reg;

    // ========================================================
    // Control fields
    always_comb begin
        ctrl_next = ctrl_reg;
        if (do_wr) begin
            ctrl_next = sreg_req.wdata & wr_mask;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= HCR_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ========================================================
    // Deactivation counter
    logic cnt_inc;

    // Suppression only exists with the virtual SGI feature
    assign cnt_inc = unmatched_deact
        && !(VSGI_FEAT && unmatched_is_vsgi
             && ctrl_reg[VSGI_BIT]);

    // Increment and a same-cycle write both apply: it lands on top
    always_comb begin
        count_next = count_reg;
        if (do_wr) begin
            count_next = sreg_req.wdata[CNT_LSB +: CNT_W];
        end
        if (cnt_inc) begin
            count_next = count_next + 5'h1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= HCR_RESET[CNT_LSB +: CNT_W];
        end else begin
            count_reg <= count_next;
        end
    end

    // ========================================================
    // Maintenance interrupt
    logic en;
    assign en = ctrl_reg[EN_BIT];

    always_comb begin
        maint_next = 1'b0;
        if (ctrl_reg[G1_OFF_BIT] && !vgroup1_signal_on) begin
            maint_next = 1'b1;
        end
        if (ctrl_reg[G1_ON_BIT] && vgroup1_signal_on) begin
            maint_next = 1'b1;
        end
        if (ctrl_reg[G0_OFF_BIT] && !vgroup0_signal_on) begin
            maint_next = 1'b1;
        end
        if (ctrl_reg[G0_ON_BIT] && vgroup0_signal_on) begin
            maint_next = 1'b1;
        end
        if (ctrl_reg[NOPEND_BIT]
            && !any_pending(list_register_entry)) begin
            maint_next = 1'b1;
        end
        if (ctrl_reg[MISSING_BIT] && count_reg != '0) begin
            maint_next = 1'b1;
        end
        if (ctrl_reg[UNDERFLOW_BIT]
            && few_valid(list_register_entry)) begin
            maint_next = 1'b1;
        end
        maint_next = maint_next && en;
    end

    // Registered so the output is glitch free; one cycle late
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            maint_reg <= 1'b0;
        end else begin
            maint_reg <= maint_next;
        end
    end

    assign maint_irq = maint_reg;

    // ========================================================
    // Guest access traps
    // Class decode lives upstream; only the trap bits live here
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            gtrap_reg <= 1'b0;
        end else begin
            gtrap_reg <= guest_acc_valid
                && ((guest_acc_grp1 && ctrl_reg[TG1_BIT])
                 || (guest_acc_grp0 && ctrl_reg[TG0_BIT])
                 || (guest_acc_common && ctrl_reg[TCOM_BIT]));
        end
    end

    assign guest_acc_trap = gtrap_reg;

    // ========================================================
    // Local system error routing
    // Support gates the stored bit too, in case it drops later
    logic serr_trap;
    assign serr_trap = ctrl_reg[TSERR_BIT] && serror_gen_supported;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            serr_hyp_reg   <= 1'b0;
            serr_guest_reg <= 1'b0;
        end else begin
            serr_hyp_reg   <= local_system_error && serr_trap;
            serr_guest_reg <= local_system_error && !serr_trap;
        end
    end

    assign serror_to_hyp   = serr_hyp_reg;
    assign serror_to_guest = serr_guest_reg;

    // ========================================================
    // Virtual interrupt gating and acknowledge
    // Enable clear also drops an interrupt already in flight
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            virq_reg <= 1'b0;
        end else begin
            virq_reg <= virq_in && en;
        end
    end

    assign virq_out = virq_reg;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            iack_reg     <= '0;
            iack_vld_reg <= 1'b0;
        end else begin
            iack_vld_reg <= iack_rd;
            if (iack_rd) begin
                iack_reg <= en ? iack_id_in : SPURIOUS_ID;
            end
        end
    end

    assign iack_id_out = iack_reg;
    assign iack_valid  = iack_vld_reg;

endmodule

// file: src/vhc_pkg.sv
// Package: constants and carriers for the hypervisor control register
package vhc_pkg;

    // ========================================================
    // Register field positions
    localparam int EN_BIT        = 0;
    localparam int UNDERFLOW_BIT = 1;
    localparam int MISSING_BIT   = 2;
    localparam int NOPEND_BIT    = 3;
    localparam int G0_ON_BIT     = 4;
    localparam int G0_OFF_BIT    = 5;
    localparam int G1_ON_BIT     = 6;
    localparam int G1_OFF_BIT    = 7;
    localparam int VSGI_BIT      = 8;
    localparam int TCOM_BIT      = 10;
    localparam int TG0_BIT       = 11;
    localparam int TG1_BIT       = 12;
    localparam int TSERR_BIT     = 13;
    localparam int CNT_LSB       = 27;
    localparam int CNT_W         = 5;

    // ========================================================
    // Reset values and writable mask
    localparam logic [31:0] HCR_RESET  = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK  = 32'h0000_3DFF;
    localparam logic [31:0] CNT_MASK   = 32'hF800_0000;
    localparam logic [31:0] SERR_MASK  = 32'h0000_2000;
    localparam logic [31:0] VSGI_MASK  = 32'h0000_0100;

    // ========================================================
    // System register encoding of the control register
    localparam logic [3:0] ENC_COPROC = 4'hF;
    localparam logic [2:0] ENC_OPC1   = 3'h4;
    localparam logic [3:0] ENC_CRN    = 4'hC;
    localparam logic [3:0] ENC_CRM    = 4'hB;
    localparam logic [2:0] ENC_OPC2   = 3'h0;

    // ========================================================
    // Levels, codes, identifiers
    localparam logic [1:0] LVL_USER    = 2'h0;
    localparam logic [1:0] LVL_KERNEL  = 2'h1;
    localparam logic [1:0] LVL_HYP     = 2'h2;
    localparam logic [1:0] LVL_MON     = 2'h3;
    localparam logic [5:0] TRAP_CODE   = 6'h03;
    localparam logic [1:0] LR_INVALID  = 2'h0;
    localparam logic [1:0] LR_PENDING  = 2'h1;
    localparam logic [23:0] SPURIOUS_ID = 24'h00_03FF;

    // ========================================================
    // Carriers
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  level;
        logic [3:0]  coproc;
        logic [2:0]  opc1;
        logic [3:0]  crn;
        logic [3:0]  crm;
        logic [2:0]  opc2;
        logic [31:0] wdata;
    } vhc_req_type;

    typedef struct packed {
        logic        valid;
        logic        undef;
        logic        trap;
        logic [5:0]  code;
        logic [31:0] rdata;
    } vhc_rsp_type;

    typedef struct packed {
        logic [1:0] state;
        logic       hw;
        logic       eoi;
    } vhc_lr_type;

endpackage

// file: verif/vhc_core_model.sv
// Partner: processor core issuing control register accesses
`timescale 1ns/1ns

module vhc_core_model (
    input  wire logic           core_clk,
    output vhc_pkg::vhc_req_type sreg_req,
    input  vhc_pkg::vhc_rsp_type sreg_rsp
);
    import vhc_pkg::*;

    initial sreg_req = '0;

    // ========================================================
    // One access, answered one cycle later
    task automatic access(input logic wr, input logic [1:0] lvl,
                          input logic [2:0] op2, input logic [31:0] wd,
                          output vhc_rsp_type rsp);
        @(posedge core_clk);
        #1;
        sreg_req = '{1'b1, wr, lvl, ENC_COPROC, ENC_OPC1, ENC_CRN,
                     ENC_CRM, op2, wd};
        @(posedge core_clk);
        #1;
        rsp = sreg_rsp;
        // Released data inverted so stale values never look valid
        sreg_req.valid = 1'b0;
        sreg_req.wdata = ~wd;
    endtask
endmodule

// file: verif/vhc_ctrl_properties.sv
// Checker: port-level properties of the hypervisor control block
`timescale 1ns/1ns

module vhc_ctrl_properties (
    input wire logic           core_clk,
    input wire logic           nrst,
    input vhc_pkg::vhc_req_type sreg_req,
    input wire logic           hyp_iface_on,
    input wire logic           mon_iface_on,
    input wire logic           hyp_enabled,
    input wire logic           coproc_group12_trap,
    input vhc_pkg::vhc_rsp_type sreg_rsp,
    input wire logic           serror_gen_supported,
    input wire logic           guest_acc_valid,
    input wire logic           guest_acc_trap,
    input wire logic           local_system_error,
    input wire logic           serror_to_hyp,
    input wire logic           serror_to_guest,
    input wire logic           virq_in,
    input wire logic           virq_out,
    input wire logic           iack_rd,
    input wire logic [23:0]    iack_id_out,
    input wire logic           iack_valid,
    input wire logic           maint_irq
);
    import vhc_pkg::*;
    logic enc_ok;
    logic acc_ok;
    logic en_reg;

    // ========================================================
    // Shadow of the enable bit, from accepted writes only
    assign enc_ok = {sreg_req.coproc, sreg_req.opc1, sreg_req.crn,
        sreg_req.crm, sreg_req.opc2} == {ENC_COPROC, ENC_OPC1, ENC_CRN,
        ENC_CRM, ENC_OPC2};
    assign acc_ok = sreg_req.valid && enc_ok &&
        ((sreg_req.level == LVL_HYP && hyp_iface_on) ||
         (sreg_req.level == LVL_MON && mon_iface_on));
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            en_reg <= 1'b0;
        end else if (acc_ok && sreg_req.write) begin
            en_reg <= sreg_req.wdata[EN_BIT];
        end
    end

    // ========================================================
    // Properties
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_rsp_pulse: assert property (
        sreg_rsp.valid == $past(sreg_req.valid))
        else $error("response not one cycle after request");
    a_user_undef: assert property (
        sreg_req.valid && sreg_req.level == LVL_USER
        |=> sreg_rsp.undef && !sreg_rsp.trap)
        else $error("user access not undefined");
    a_iface_gate: assert property (
        sreg_req.valid && enc_ok && sreg_req.level == LVL_HYP && !hyp_iface_on
        |=> sreg_rsp.undef)
        else $error("hyp access without interface enable");
    a_kernel_trap: assert property (
        sreg_req.valid && enc_ok && sreg_req.level == LVL_KERNEL &&
        hyp_enabled && coproc_group12_trap
        |=> sreg_rsp.trap && sreg_rsp.code == TRAP_CODE)
        else $error("kernel access did not trap with code 3");
    a_reserved_zero: assert property (
        acc_ok && !sreg_req.write
        |=> sreg_rsp.rdata[26:14] == '0 && !sreg_rsp.rdata[9])
        else $error("reserved bits read nonzero");
    a_serror_one: assert property (
        local_system_error |=> serror_to_hyp != serror_to_guest)
        else $error("system error not routed exactly once");
    a_serror_unsup: assert property (
        local_system_error && !serror_gen_supported
        |=> serror_to_guest && !serror_to_hyp)
        else $error("system error trapped without support");
    a_quiet_off: assert property (
        !en_reg |=> !virq_out && !maint_irq)
        else $error("signalling while disabled");
    a_virq_pass: assert property (
        virq_in && en_reg |=> virq_out)
        else $error("virtual interrupt lost while enabled");
    a_spurious_id: assert property (
        iack_rd && !en_reg |=> iack_valid && iack_id_out == SPURIOUS_ID)
        else $error("acknowledge not spurious while disabled");
    a_guest_idle: assert property (
        !guest_acc_valid |=> !guest_acc_trap)
        else $error("guest trap without access");
endmodule

// file: verif/vhc_ctrl_test.sv
// Testbench: self-checking run of the hypervisor control block
`timescale 1ns/1ns

module vhc_ctrl_test;
    import vhc_pkg::*;
    logic core_clk, nrst, hyp_iface_on, mon_iface_on, hyp_enabled;
    logic coproc_group12_trap, vgroup0_signal_on, vgroup1_signal_on;
    logic serror_gen_supported, unmatched_deact, unmatched_is_vsgi;
    logic guest_acc_valid, guest_acc_grp0, guest_acc_grp1;
    logic guest_acc_common, guest_acc_trap, local_system_error;
    logic serror_to_hyp, serror_to_guest, virq_in, virq_out;
    logic iack_rd, iack_valid, maint_irq;
    logic [23:0] iack_id_in, iack_id_out;
    vhc_req_type sreg_req;
    vhc_rsp_type sreg_rsp, mon_rsp;
    vhc_lr_type  list_register_entry [16];
    int          errors, checks;

    vhc_ctrl u_dut (.core_clk, .nrst, .sreg_req, .hyp_iface_on, .mon_iface_on,
        .hyp_enabled, .coproc_group12_trap, .sreg_rsp,
        .list_register_entry, .vgroup0_signal_on, .vgroup1_signal_on,
        .serror_gen_supported, .unmatched_deact, .unmatched_is_vsgi,
        .guest_acc_valid, .guest_acc_grp0, .guest_acc_grp1,
        .guest_acc_common, .guest_acc_trap, .local_system_error,
        .serror_to_hyp, .serror_to_guest, .virq_in, .virq_out, .iack_rd,
        .iack_id_in, .iack_id_out, .iack_valid, .maint_irq);
    vhc_core_model u_core (.core_clk, .sreg_req, .sreg_rsp);

    // ========================================================
    // Tasks
    task automatic step;
        @(posedge core_clk);
        #1;
    endtask
    task automatic check_word(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_bit(input string nm, input logic e, g);
        check_word(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic wr(input logic [31:0] d);
        vhc_rsp_type r;
        u_core.access(1'b1, LVL_HYP, ENC_OPC2, d, r);
    endtask
    task automatic rd(input logic [31:0] e, input string nm);
        vhc_rsp_type r;
        u_core.access(1'b0, LVL_HYP, ENC_OPC2, 32'h0000_0000, r);
        check_word(nm, e, r.rdata);
    endtask
    // Refused write of the enable bit; trap expected or undefined
    task automatic refuse(input logic [1:0] lvl, input logic [2:0] op2,
                          input logic t);
        vhc_rsp_type r;
        u_core.access(1'b1, lvl, op2, 32'h0000_0001, r);
        check_bit("undef", !t, r.undef);
        check_bit("trap", t, r.trap);
        check_bit("valid", 1'b1, r.valid);
        if (t) check_word("code", {26'h0, TRAP_CODE}, {26'h0, r.code});
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        errors++;
        print_verdict;
    end

    // ========================================================
    // Main sequence
    initial begin
        {nrst, hyp_enabled, coproc_group12_trap, vgroup0_signal_on,
         vgroup1_signal_on, unmatched_deact, unmatched_is_vsgi,
         guest_acc_valid, guest_acc_grp0, guest_acc_grp1,
         guest_acc_common, local_system_error, virq_in, iack_rd} = '0;
        {hyp_iface_on, mon_iface_on, serror_gen_supported} = 3'h7;
        iack_id_in = 24'h00_0123;
        errors = 0;
        checks = 0;
        foreach (list_register_entry[i]) list_register_entry[i] = 4'h4;
        repeat (20) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        rd(32'h0000_0000, "reset value");
        wr(32'hFFFF_FFFF);
        rd(32'hF800_3DFF, "all ones");
        serror_gen_supported = 1'b0;
        wr(32'h0000_2000);
        rd(32'h0000_0000, "serror masked");
        // Third pass writes bit 13 without support: must stay local
        for (int b = 0; b < 3; b++) begin
            serror_gen_supported = (b < 2);
            wr({18'h0, b != 0, 13'h0});
            step;
            local_system_error = 1'b1;
            step;
            check_bit("to hyp", b == 1, serror_to_hyp);
            check_bit("to guest", b != 1, serror_to_guest);
            local_system_error = 1'b0;
        end
        serror_gen_supported = 1'b1;
        refuse(LVL_USER, ENC_OPC2, 1'b0);
        hyp_iface_on = 1'b0;
        refuse(LVL_HYP, ENC_OPC2, 1'b0);
        hyp_iface_on = 1'b1;
        mon_iface_on = 1'b0;
        refuse(LVL_MON, ENC_OPC2, 1'b0);
        mon_iface_on = 1'b1;
        refuse(LVL_HYP, 3'h3, 1'b0);
        refuse(LVL_KERNEL, ENC_OPC2, 1'b0);
        hyp_enabled = 1'b1;
        refuse(LVL_KERNEL, ENC_OPC2, 1'b0);
        {hyp_enabled, coproc_group12_trap} = 2'h3;
        refuse(LVL_KERNEL, ENC_OPC2, 1'b1);
        rd(32'h0000_0000, "refused writes");
        u_core.access(1'b0, LVL_MON, ENC_OPC2, 32'h0000_0000, mon_rsp);
        check_bit("mon undef", 1'b0, mon_rsp.undef);
        // Trap bits 10..12 against access classes common, g0, g1
        for (int i = 0; i < 3; i++) begin
            wr(32'h0000_0400 << i);
            for (int j = 0; j < 3; j++) begin
                step;
                guest_acc_valid = 1'b1;
                {guest_acc_grp1, guest_acc_grp0, guest_acc_common} =
                    3'h1 << j;
                step;
                check_bit("guest trap", i == j, guest_acc_trap);
                guest_acc_valid = 1'b0;
            end
        end
        for (int i = 4; i < 8; i++) begin
            for (int v = 0; v < 2; v++) begin
                {vgroup0_signal_on, vgroup1_signal_on} = {2{v[0]}};
                wr(32'h0000_0001 | (32'h0000_0001 << i));
                step;
                step;
                check_bit("grp", i[0]^v[0], maint_irq);
            end
        end
        wr(32'h0000_0009);
        foreach (list_register_entry[i]) list_register_entry[i] = 4'h8;
        step;
        step;
        check_bit("none pending", 1'b1, maint_irq);
        list_register_entry[3] = 4'h4;
        step;
        step;
        check_bit("one pending", 1'b0, maint_irq);
        wr(32'h0000_0003);
        foreach (list_register_entry[i]) list_register_entry[i] = 4'h0;
        step;
        step;
        check_bit("empty", 1'b1, maint_irq);
        list_register_entry[5] = 4'h1;
        step;
        step;
        check_bit("one valid", 1'b1, maint_irq);
        list_register_entry[6] = 4'h8;
        step;
        step;
        check_bit("two valid", 1'b0, maint_irq);
        wr(32'h0000_0105);
        for (int k = 0; k < 3; k++) begin
            step;
            unmatched_deact = 1'b1;
            unmatched_is_vsgi = (k == 0);
            step;
            unmatched_deact = 1'b0;
            if (k == 0) begin
                step;
                check_bit("vsgi held", 1'b0, maint_irq);
            end
        end
        step;
        step;
        check_bit("count maint", 1'b1, maint_irq);
        rd(32'h1000_0105, "count");
        virq_in = 1'b1;
        for (int b = 0; b < 2; b++) begin
            wr(32'h1000_0104 | b);
            step;
            step;
            check_bit("maint gate", b[0], maint_irq);
            check_bit("virq gate", b[0], virq_out);
            iack_rd = 1'b1;
            step;
            iack_rd = 1'b0;
            check_word("iack id", b ? 32'h0000_0123 : {8'h0, SPURIOUS_ID},
                       {8'h0, iack_id_out});
            check_bit("iack valid", 1'b1, iack_valid);
        end
        nrst = 1'b0;
        step;
        nrst = 1'b1;
        rd(32'h0000_0000, "warm reset");
        print_verdict;
    end
endmodule

bind vhc_ctrl vhc_ctrl_properties u_props (.core_clk, .nrst, .sreg_req,
    .hyp_iface_on, .mon_iface_on, .hyp_enabled, .coproc_group12_trap,
    .sreg_rsp, .serror_gen_supported, .guest_acc_valid, .guest_acc_trap,
    .local_system_error, .serror_to_hyp, .serror_to_guest, .virq_in,
    .virq_out, .iack_rd, .iack_id_out, .iack_valid, .maint_irq);
